// *** logic/acr_pkg.sv ***
// Overview of operation
// - low three bits read the strap pins
// - bit 3 reserved, reads zero, unused
// - soft hold ack stays zero unless pseudo-DMA
// - pseudo-DMA replaces grant pin with soft ack
// - pseudo-DMA state: idle, pending, in progress
// - bit 5 shows pseudo-DMA direction
// - bit 6 shows bus request as 1, pin polarity by strap
// - bit 7 selects pseudo-DMA over bus master
// - bit 8 resets core, register stays reachable
// - clock failure sets adapter reset bit
// - bit 9 halts the internal processor
// - bit 10 picks ROM or RAM chapters
// - host writes zero to bit 11
// - bit 12 enables system interrupt requests
// - interrupt pin from pending request or enabled status
// - bit 13 enables odd parity checking
// - bits 14-15 drive net select, written in reset
// - select codes: speed bit, type bit
// - power-up select is 16 Mbps token ring
// - board wires select outputs to straps
// - strap inputs stay fixed during operation, except the two wired to the select outputs
package acr_pkg;
    localparam int DATA_W = 16;
    localparam int STRAP_LO = 0;
    localparam int STRAP_HI = 2;
    localparam int RSVD_BIT = 3;
    localparam int SHA_BIT = 4;
    localparam int DIR_BIT = 5;
    localparam int BREQ_BIT = 6;
    localparam int PDMA_BIT = 7;
    localparam int ARST_BIT = 8;
    localparam int HALT_BIT = 9;
    localparam int BOOT_BIT = 10;
    localparam int RESERVED_ZERO_BIT_BIT = 11;
    localparam int IEN_BIT = 12;
    localparam int PEN_BIT = 13;
    localparam int NSEL_LO = 14;
    localparam int NSEL_HI = 15;
    localparam logic [15:0] RESERVED_ZERO_BIT_MASK = 16'h0800;
    localparam logic [4:0] CHAPTER_FIRST = 5'h00;
    localparam logic [4:0] CHAPTER_LAST = 5'h1f;
    // reset values of the stored bits
    localparam logic SHA_RST = 1'b0;
    localparam logic PDMA_RST = 1'b0;
    localparam logic ARST_RST = 1'b0;
    localparam logic HALT_RST = 1'b1;
    localparam logic IEN_RST = 1'b0;
    // out1 = 1 (type), out0 = 0 (speed)
    localparam logic [1:0] NSEL_RST = 2'h2;
    localparam logic [1:0] NSEL_TR16 = 2'h2;
    localparam logic [1:0] NSEL_ETH = 2'h1;
    localparam logic [1:0] NSEL_TR4 = 2'h3;
    localparam logic [1:0] NSEL_RSVD = 2'h0;
    // controller register map, byte offsets
    localparam int HOST_AW = 4;
    localparam logic [3:0] H_DIO_WRITE = 4'h0;
    localparam logic [3:0] H_DIO_READ = 4'h4;
    localparam logic [3:0] H_DIO_RESULT = 4'h8;
    localparam logic [3:0] H_PINS = 4'hc;
    localparam int H_VALID_BIT = 16;
    typedef enum logic [1:0] {
        PDMA_IDLE = 2'b00,
        PDMA_PENDING = 2'b01,
        PDMA_ACTIVE = 2'b10,
        PDMA_OFF = 2'b11
    } acr_pdma_state_t;
endpackage

// *** logic/acr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface acr_link_if;
    logic dio_wr;
    logic dio_rd;
    logic [15:0] dio_wdata;
    logic [15:0] dio_rdata;
    logic hold_ack_grant_pin;
    logic bus_request_pin;
    logic host_irq_pin;
    logic [1:0] net_select_out;
    modport device (
        input dio_wr,
        input dio_rd,
        input dio_wdata,
        output dio_rdata,
        input hold_ack_grant_pin,
        output bus_request_pin,
        output host_irq_pin,
        output net_select_out
    );
    modport host (
        output dio_wr,
        output dio_rd,
        output dio_wdata,
        input dio_rdata,
        output hold_ack_grant_pin,
        input bus_request_pin,
        input host_irq_pin,
        input net_select_out
    );
endinterface
`default_nettype wire

// *** logic/acr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// no reset: the chain only tracks pins, reset must cover its depth
module acr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                meta_q[i] <= d[i];
                q[i] <= meta_q[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** logic/acr_device_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_device_end (
    input wire logic CORE_CLK,
    input wire logic RESET,
    acr_link_if.device LINK,
    input wire logic [2:0] NET_STRAP,
    input wire logic HOST_SEL_STRAP,
    input wire logic BOOT_DEFAULT_STRAP,
    input wire logic PARITY_DEFAULT_STRAP,
    input wire logic CLOCK_FAIL,
    input wire logic DMA_REQUEST,
    input wire logic PDMA_DIRECTION_SIGNAL,
    input wire logic SYSTEM_INTERRUPT,
    input wire logic MEM_CYCLE,
    input wire logic [4:0] MEM_CHAPTER,
    input wire logic XFER_VALID,
    input wire logic [15:0] XFER_DATA,
    input wire logic [1:0] XFER_PARITY,
    output logic CORE_RESET,
    output logic PROCESSOR_HALT,
    output logic BUS_GRANT,
    output logic [1:0] PDMA_STATE,
    output logic PARITY_ERROR,
    output logic COLUMN_STROBE_OUT_N,
    output logic ROM_ENABLE_OUT_N
);
    logic [7:0] pin_s;
    logic [2:0] strap_s;
    logic host_sel_s;
    logic boot_strap_s;
    logic parity_strap_s;
    logic hold_pin_s;
    logic clk_fail_s;

    acr_sync #(
        .W(8)
    ) u_sync (
        .clk(CORE_CLK),
        .d({CLOCK_FAIL, LINK.hold_ack_grant_pin, HOST_SEL_STRAP, PARITY_DEFAULT_STRAP,
            BOOT_DEFAULT_STRAP, NET_STRAP}),
        .q(pin_s)
    );

    assign strap_s = pin_s[2:0];
    assign boot_strap_s = pin_s[3];
    assign parity_strap_s = pin_s[4];
    assign host_sel_s = pin_s[5];
    assign hold_pin_s = pin_s[6];
    assign clk_fail_s = pin_s[7];

    logic sha_q;
    logic pdma_q;
    logic adapter_reset_bit_q;
    logic halt_q;
    logic boot_q;
    logic ien_q;
    logic pen_q;
    logic [1:0] nsel_q;
    logic sha_d;
    logic pdma_d;
    logic adapter_reset_bit_d;
    logic halt_d;
    logic boot_d;
    logic ien_d;
    logic pen_d;
    logic [1:0] nsel_d;

    wire wr = LINK.dio_wr;
    wire [15:0] wd = LINK.dio_wdata;

    assign pdma_d = wr ? wd[acr_pkg::PDMA_BIT] : pdma_q;
    // a one is accepted only together with the enable in the same word
    assign sha_d = pdma_d & (wr ? wd[acr_pkg::SHA_BIT] : sha_q);
    // clock failure wins over a write that clears the bit
    assign adapter_reset_bit_d = clk_fail_s | (wr ? wd[acr_pkg::ARST_BIT] : adapter_reset_bit_q);
    assign halt_d = wr ? wd[acr_pkg::HALT_BIT] : halt_q;
    assign boot_d = wr ? wd[acr_pkg::BOOT_BIT] : boot_q;
    assign ien_d = wr ? wd[acr_pkg::IEN_BIT] : ien_q;
    assign pen_d = wr ? wd[acr_pkg::PEN_BIT] : pen_q;
    // old bit gates the write, so setting reset and select needs two writes
    assign nsel_d = (wr && adapter_reset_bit_q) ? wd[acr_pkg::NSEL_HI:acr_pkg::NSEL_LO] : nsel_q;

    // only the pin reset clears the register; the reset bit leaves it alone
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            sha_q <= acr_pkg::SHA_RST;
            pdma_q <= acr_pkg::PDMA_RST;
            adapter_reset_bit_q <= acr_pkg::ARST_RST;
            halt_q <= acr_pkg::HALT_RST;
            boot_q <= boot_strap_s;
            ien_q <= acr_pkg::IEN_RST;
            pen_q <= parity_strap_s;
            nsel_q <= acr_pkg::NSEL_RST;
        end
        else
        begin
            sha_q <= sha_d;
            pdma_q <= pdma_d;
            adapter_reset_bit_q <= adapter_reset_bit_d;
            halt_q <= halt_d;
            boot_q <= boot_d;
            ien_q <= ien_d;
            pen_q <= pen_d;
            nsel_q <= nsel_d;
        end
    end

    wire core_rst = RESET | adapter_reset_bit_q;
    // pin polarity follows the host-select strap; view is 1 when requested
    wire breq_view = host_sel_s ? LINK.bus_request_pin : ~LINK.bus_request_pin;
    wire breq_pin_d = host_sel_s ? DMA_REQUEST : ~DMA_REQUEST;
    wire breq_idle = ~host_sel_s;
    wire grant_src = pdma_q ? sha_q : hold_pin_s;
    wire irq_d = (pdma_q & breq_view & ~sha_q) | (ien_q & SYSTEM_INTERRUPT);

    wire [15:0] rd_word = {
        nsel_q,
        pen_q,
        ien_q,
        1'b0,
        boot_q,
        halt_q,
        adapter_reset_bit_q,
        pdma_q,
        breq_view,
        PDMA_DIRECTION_SIGNAL,
        sha_q,
        1'b0,
        strap_s
    };

    acr_pkg::acr_pdma_state_t pdma_st;

    always_comb
    begin
        case ({pdma_q, sha_q, breq_view})
            3'b100: pdma_st = acr_pkg::PDMA_IDLE;
            3'b101: pdma_st = acr_pkg::PDMA_PENDING;
            3'b110: pdma_st = acr_pkg::PDMA_ACTIVE;
            3'b111: pdma_st = acr_pkg::PDMA_ACTIVE;
            default: pdma_st = acr_pkg::PDMA_OFF;
        endcase
    end

    // odd parity per byte, high byte uses parity bit 1
    wire par_bad = ~^{XFER_DATA[15:8], XFER_PARITY[1]} | ~^{XFER_DATA[7:0], XFER_PARITY[0]};
    wire par_err_d = pen_q & XFER_VALID & par_bad;

    wire rom_chapter = (MEM_CHAPTER == acr_pkg::CHAPTER_FIRST) | (MEM_CHAPTER == acr_pkg::CHAPTER_LAST);
    wire rom_sel = MEM_CYCLE & ~boot_q & rom_chapter;
    wire cas_sel = MEM_CYCLE & ~rom_sel;

    // register port answers even while the reset bit holds the core in reset, but not during pin reset
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            LINK.dio_rdata <= 16'h0000;
        end
        else
        begin
            LINK.dio_rdata <= LINK.dio_rd ? rd_word : 16'h0000;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            LINK.net_select_out <= acr_pkg::NSEL_RST;
            LINK.host_irq_pin <= 1'b0;
            PDMA_STATE <= acr_pkg::PDMA_OFF;
        end
        else
        begin
            LINK.net_select_out <= nsel_q;
            LINK.host_irq_pin <= irq_d;
            PDMA_STATE <= pdma_st;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        CORE_RESET <= core_rst;
        if (core_rst)
        begin
            PROCESSOR_HALT <= 1'b1;
            BUS_GRANT <= 1'b0;
            PARITY_ERROR <= 1'b0;
            LINK.bus_request_pin <= breq_idle;
            COLUMN_STROBE_OUT_N <= 1'b1;
            ROM_ENABLE_OUT_N <= 1'b1;
        end
        else
        begin
            PROCESSOR_HALT <= halt_q;
            BUS_GRANT <= grant_src;
            PARITY_ERROR <= par_err_d;
            LINK.bus_request_pin <= breq_pin_d;
            COLUMN_STROBE_OUT_N <= ~cas_sel;
            ROM_ENABLE_OUT_N <= ~rom_sel;
        end
    end
endmodule
`default_nettype wire

// *** logic/acr_host_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_host_end (
    input wire logic CORE_CLK,
    input wire logic RESET,
    acr_link_if.host LINK,
    input wire logic [3:0] SW_ADDR,
    input wire logic [31:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [31:0] SW_RDATA
);
    logic [3:0] pins_s;
    logic rd_pend_q;
    logic valid_q;
    logic [15:0] result_q;
    logic grant_q;

    // device pins are treated as foreign to this clock
    acr_sync #(
        .W(4)
    ) u_sync (
        .clk(CORE_CLK),
        .d({LINK.host_irq_pin, LINK.bus_request_pin, LINK.net_select_out}),
        .q(pins_s)
    );

    wire wr_dio = SW_WR && (SW_ADDR == acr_pkg::H_DIO_WRITE);
    wire rd_dio = SW_WR && (SW_ADDR == acr_pkg::H_DIO_READ);
    wire wr_pins = SW_WR && (SW_ADDR == acr_pkg::H_PINS);
    wire rd_result = SW_RD && (SW_ADDR == acr_pkg::H_DIO_RESULT);
    wire rd_pins = SW_RD && (SW_ADDR == acr_pkg::H_PINS);
    // a fresh result wins over the read that clears the flag
    wire valid_d = rd_pend_q | (valid_q & ~rd_result);
    wire [31:0] result_word = {15'h0, valid_q, result_q};
    wire [31:0] pins_word = {28'h0000000, pins_s};
    wire [31:0] rdata_d = rd_result ? result_word : (rd_pins ? pins_word : 32'h00000000);

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            LINK.dio_wr <= 1'b0;
            LINK.dio_rd <= 1'b0;
            LINK.dio_wdata <= 16'h0000;
            LINK.hold_ack_grant_pin <= 1'b0;
            grant_q <= 1'b0;
            rd_pend_q <= 1'b0;
            valid_q <= 1'b0;
            result_q <= 16'h0000;
            SW_RDATA <= 32'h00000000;
        end
        else
        begin
            LINK.dio_wr <= wr_dio;
            LINK.dio_rd <= rd_dio;
            if (wr_dio)
            begin
                LINK.dio_wdata <= SW_WDATA[15:0] & ~acr_pkg::RESERVED_ZERO_BIT_MASK;
            end
            if (wr_pins)
            begin
                grant_q <= SW_WDATA[0];
            end
            LINK.hold_ack_grant_pin <= grant_q;
            rd_pend_q <= LINK.dio_rd;
            if (rd_pend_q)
            begin
                result_q <= LINK.dio_rdata;
            end
            valid_q <= valid_d;
            SW_RDATA <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// *** tb/acr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_chk (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic dio_wr,
    input wire logic dio_rd,
    input wire logic [15:0] dio_wdata,
    input wire logic [15:0] dio_rdata,
    input wire logic host_irq_pin,
    input wire logic [1:0] net_select_out
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    a_rsvd_zero: assert property (dio_rd |=> !dio_rdata[3] && !dio_rdata[11])
        else $error("reserved bit read as one");
    a_sha_gate: assert property (dio_rd |=> !dio_rdata[4] || dio_rdata[7])
        else $error("soft ack set without pseudo dma");
    a_sha_clear: assert property (dio_wr && !dio_wdata[7] ##1 !dio_wr ##1 dio_rd |=> !dio_rdata[4])
        else $error("soft ack kept after pseudo dma off");
    a_nsel_cause: assert property ($changed(net_select_out) |-> $past(dio_wr, 2))
        else $error("select outputs moved with no write");
    a_nsel_view: assert property (dio_rd |=> dio_rdata[15:14] == net_select_out)
        else $error("select bits differ from pins");
    // the write one cycle after the read is gated by the bit it showed
    a_nsel_locked: assert property (dio_rd ##1 !dio_rdata[8] |=> ##1 $stable(net_select_out))
        else $error("select outputs written out of reset");
    a_power_sel: assert property ($fell(RESET) |-> net_select_out == 2'h2)
        else $error("select outputs wrong after reset");
    a_reserved_zero_bit_wr: assert property (dio_wr |-> !dio_wdata[11])
        else $error("bit eleven written as one");
    a_irq_busy: assert property (dio_rd ##1 (dio_rdata[7] && dio_rdata[4] && !dio_rdata[12]) |-> !host_irq_pin)
        else $error("interrupt during transfer");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic CORE_CLK = 1'h0;
    logic RESET = 1'h1;
    logic dreq = 1'h0, ddir = 1'h0, sint = 1'h0, memc = 1'h0, xv = 1'h0, cf = 1'h0, hsel = 1'h1;
    logic sww = 1'h0, swr = 1'h0, seen;
    logic [4:0] mch = 5'h00;
    logic [1:0] xp = 2'h3, pst;
    logic [3:0] sa = 4'h0;
    logic [31:0] swd = 32'h0, swq, rd;
    logic core_rst, halt, grant, perr, cas_n, rom_n;
    int err_count = 0, comparisons = 0, cyc = 0;
    initial forever #5 CORE_CLK = ~CORE_CLK;
    acr_link_if link();
    // board ties select outputs to the straps, third strap high
    acr_device_end u_acr_device_end (.CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(link),
        .NET_STRAP({1'h1, link.net_select_out}), .HOST_SEL_STRAP(hsel), .BOOT_DEFAULT_STRAP(1'h1),
        .PARITY_DEFAULT_STRAP(1'h1), .CLOCK_FAIL(cf), .DMA_REQUEST(dreq), .PDMA_DIRECTION_SIGNAL(ddir),
        .SYSTEM_INTERRUPT(sint), .MEM_CYCLE(memc), .MEM_CHAPTER(mch), .XFER_VALID(xv),
        .XFER_DATA(16'h0), .XFER_PARITY(xp), .CORE_RESET(core_rst), .PROCESSOR_HALT(halt),
        .BUS_GRANT(grant), .PDMA_STATE(pst), .PARITY_ERROR(perr), .COLUMN_STROBE_OUT_N(cas_n),
        .ROM_ENABLE_OUT_N(rom_n));
    acr_host_end u_acr_host_end (.CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(link), .SW_ADDR(sa),
        .SW_WDATA(swd), .SW_WR(sww), .SW_RD(swr), .SW_RDATA(swq));
    acr_chk u_acr_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .dio_wr(link.dio_wr),
        .dio_rd(link.dio_rd), .dio_wdata(link.dio_wdata), .dio_rdata(link.dio_rdata),
        .host_irq_pin(link.host_irq_pin), .net_select_out(link.net_select_out));
    task stop_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task hang;
        err_count++;
        stop_test;
    endtask
    always @(posedge CORE_CLK) if (++cyc == 3000) hang;
    task sw(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge CORE_CLK);
        sa <= a;
        swd <= d;
        sww <= w;
        swr <= !w;
        @(posedge CORE_CLK);
        sww <= 1'h0;
        swr <= 1'h0;
        #1 rd = swq;
    endtask
    task wr(input logic [15:0] d);
        sw(acr_pkg::H_DIO_WRITE, {16'h0, d}, 1'h1);
    endtask
    task rdw(input logic [15:0] e);
        sw(acr_pkg::H_DIO_READ, 32'h0, 1'h1);
        repeat (2) @(posedge CORE_CLK);
        sw(acr_pkg::H_DIO_RESULT, 32'h0, 1'h0);
        `CHK(rd, {15'h0, 1'h1, e})
    endtask
    task settle;
        repeat (8) @(posedge CORE_CLK);
        #1;
    endtask
    // error is a pulse, so it is collected over a short window
    task par(input logic [1:0] p, input logic e);
        seen = 1'h0;
        @(posedge CORE_CLK);
        xv <= 1'h1;
        xp <= p;
        @(posedge CORE_CLK);
        xv <= 1'h0;
        // the pulse stands in the cycle right after the sampling edge
        repeat (3)
        begin
            #1 seen |= perr;
            @(posedge CORE_CLK);
        end
        `CHK(seen, e)
    endtask
    task mem(input logic [4:0] c, input logic cs, input logic ro);
        @(posedge CORE_CLK);
        memc <= 1'h1;
        mch <= c;
        repeat (2) @(posedge CORE_CLK);
        #1 `CHK({cas_n, rom_n}, {cs, ro})
        @(posedge CORE_CLK) memc <= 1'h0;
    endtask
    initial
    begin
        repeat (10) @(posedge CORE_CLK);
        RESET <= 1'h0;
        rdw(16'ha606);
        `CHK(halt, 1'h1)
        `CHK(pst, 2'h3)
        wr(16'h2610);
        rdw(16'ha606);
        wr(16'h2690);
        settle;
        `CHK(grant, 1'h1)
        `CHK(pst, 2'h2)
        rdw(16'ha696);
        // dropping the enable must clear a set soft ack; the host masks bit 11
        wr(16'h2e10);
        rdw(16'ha606);
        wr(16'h2680);
        settle;
        `CHK(pst, 2'h0)
        @(posedge CORE_CLK);
        dreq <= 1'h1;
        sw(acr_pkg::H_PINS, 32'h1, 1'h1);
        settle;
        `CHK(pst, 2'h1)
        `CHK(grant, 1'h0)
        `CHK(link.host_irq_pin, 1'h1)
        sw(acr_pkg::H_PINS, 32'h0, 1'h0);
        `CHK(rd, 32'h0000000e)
        rdw(16'ha6c6);
        @(posedge CORE_CLK);
        ddir <= 1'h1;
        sint <= 1'h1;
        wr(16'h2600);
        settle;
        `CHK(grant, 1'h1)
        `CHK(link.host_irq_pin, 1'h0)
        rdw(16'ha666);
        wr(16'h3600);
        settle;
        `CHK(link.host_irq_pin, 1'h1)
        @(posedge CORE_CLK);
        sint <= 1'h0;
        ddir <= 1'h0;
        dreq <= 1'h0;
        par(2'h3, 1'h0);
        par(2'h1, 1'h1);
        wr(16'h0600);
        par(2'h1, 1'h0);
        wr(16'h0400);
        settle;
        `CHK(halt, 1'h0)
        mem(5'h00, 1'h0, 1'h1);
        wr(16'h0000);
        mem(5'h1f, 1'h1, 1'h0);
        mem(5'h05, 1'h0, 1'h1);
        wr(16'h0100);
        settle;
        `CHK(core_rst, 1'h1)
        for (int i = 0; i < 2; i++)
        begin
            wr({i ? acr_pkg::NSEL_TR4 : acr_pkg::NSEL_ETH, 14'h0100});
            settle;
            `CHK(link.net_select_out, i ? acr_pkg::NSEL_TR4 : acr_pkg::NSEL_ETH)
        end
        wr(16'h4000);
        wr(16'hc000);
        settle;
        `CHK(link.net_select_out, 2'h1)
        `CHK(core_rst, 1'h0)
        @(posedge CORE_CLK) cf <= 1'h1;
        @(posedge CORE_CLK) cf <= 1'h0;
        settle;
        rdw({2'h1, 5'h0, 1'h1, 5'h0, 1'h1, 2'h1});
        `CHK(core_rst, 1'h1)
        // host-select strap moves only while the part is held in reset
        @(posedge CORE_CLK);
        RESET <= 1'h1;
        hsel <= 1'h0;
        repeat (4) @(posedge CORE_CLK);
        RESET <= 1'h0;
        rdw(16'ha606);
        @(posedge CORE_CLK);
        dreq <= 1'h1;
        settle;
        sw(acr_pkg::H_PINS, 32'h0, 1'h0);
        `CHK(rd, 32'h00000002)
        rdw(16'ha646);
        stop_test;
    end
endmodule
`default_nettype wire
